// *** core/sasc_top.sv ***
// Sample control, conversion sequencing and register slave of the converter
//
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module sasc_top (
   input  wire logic        clk_sys_i,         // System clock, 25 MHz
   input  wire logic        rst_i,             // Async reset, active high
   input  wire logic        hsel_i,            // Slave select
   input  wire logic [31:0] haddr_i,           // Byte address
   input  wire logic [1:0]  htrans_i,          // Transfer type
   input  wire logic        hwrite_i,          // Write
   input  wire logic [2:0]  hsize_i,           // Size, word only
   input  wire logic [31:0] hwdata_i,          // Write data
   input  wire logic        hready_i,          // Bus ready
   output logic      [31:0] hrdata_o,          // Read data
   output logic             hreadyout_o,       // Slave ready
   output logic             hresp_o,           // Always OKAY
   input  wire logic        sub_main_clk_i,    // Clock source 0 level
   input  wire logic        main_clk_i,        // Clock source 1 level
   input  wire logic        aux_clk_i,         // Clock source 2 level
   input  wire logic        osc_clk_i,         // Internal oscillator level
   input  wire logic        tmr_a1_i,          // Timer one output unit 1
   input  wire logic        tmr_b0_i,          // Timer two output unit 0
   input  wire logic        tmr_b1_i,          // Timer two output unit 1
   input  wire logic        comparator_i,      // High when input >= trial code
   output logic             core_power_on_o,   // Core power enable
   output logic             reference_power_on_o, // Reference power enable
   output logic             reference_level_sel_o, // High reference level
   output logic             sample_control_o,  // Sampling active
   output logic      [11:0] dac_code_o,        // Trial code to core
   output logic      [11:0] channel_connect_o, // One-hot channel switch
   output logic      [11:0] channel_ground_o,  // Middle node grounding
   output logic             busy_o,            // Busy status
   output logic             conv_tick_o        // Conversion clock tick
);
   import sasc_pkg::*;

   sasc_state_t st;
   sasc_state_t next_st;
   logic [15:0] ctl_a;
   logic [15:0] ctl_b;
   logic [15:0] flags;
   logic [7:0]  entry [N_ENTRY];
   logic [3:0]  ptr;
   logic        in_seq;
   logic        done_lock;
   logic [11:0] sar;
   logic [3:0]  bit_cnt;
   logic [5:0]  samp_cnt;
   logic        trig_q;
   logic [3:0]  chan_out;
   logic        connect;
   logic        wr_q;
   logic        rd_q;
   logic [31:0] addr_q;
   logic [11:0] mem_rdata;
   logic        conv_tick;

   // Bus address phase and register decode
   wire acc        = hsel_i & htrans_i[1] & hready_i;
   wire wr_ctl_a   = wr_q & (addr_q == OFS_CTL_A);
   wire wr_ctl_b   = wr_q & (addr_q == OFS_CTL_B);
   wire wr_flag    = wr_q & (addr_q == OFS_FLAG);
   wire hit_entry  = (addr_q[31:6] == OFS_ENTRY[31:6]);
   wire hit_result = (addr_q[31:6] == OFS_RESULT[31:6]);
   wire wr_entry   = wr_q & hit_entry;
   wire [3:0] widx = addr_q[5:2];

   // Field views
   wire arm       = ctl_a[A_ARM];
   wire core_on   = ctl_a[A_CORE_ON];
   wire [1:0] mode    = ctl_b[B_SEQ_MODE +: 2];
   wire [1:0] trg_sel = ctl_b[B_TRG_SRC +: 2];
   wire pulse     = ctl_b[B_PULSE];
   wire [3:0] start_addr = ctl_b[B_START +: 4];
   wire [7:0] cur_entry  = entry[ptr];
   wire eos       = cur_entry[E_EOS];
   wire [3:0] cur_chan   = cur_entry[E_CHAN +: 4];

   wire [3:0] trg_vec = {tmr_b1_i, tmr_b0_i, tmr_a1_i, ctl_a[A_SW_START]};
   wire trig      = trg_vec[trg_sel] ^ ctl_b[B_TRG_INV];
   wire trig_rise = trig & ~trig_q;

   // low field serves entries 0 to 7, high field 8 to 15
   wire [3:0] sht       = ptr[3] ? ctl_a[A_SHT_HI +: 4] : ctl_a[A_SHT_LO +: 4];
   wire [5:0] samp_last = {sht, 2'b11};

   // start needs arm, unless a started sequence is running out
   wire can_start = (arm | in_seq) & core_on & ~done_lock;
   // Clearing arm in single mode stops at once; result is lost
   wire abort     = ~arm & (mode == MODE_SINGLE) & ~(st == ST_IDLE);
   wire seq_mode  = mode[0];
   wire seq_more  = seq_mode & ~eos;
   wire sw_clr    = pulse & (st == ST_SAMPLE) & (next_st == ST_SYNC);

   // locked fields keep their value while armed
   wire [15:0] ctl_a_wr   = arm ? {ctl_a[15:2], hwdata_i[1:0]} : hwdata_i[15:0];
   wire [15:0] next_ctl_a = wr_ctl_a ? ctl_a_wr
                                     : {ctl_a[15:1], ctl_a[A_SW_START] & ~sw_clr};
   wire [15:0] next_ctl_b = (wr_ctl_b & ~arm) ? hwdata_i[15:0] : ctl_b;

   // set wins over a write-one clear in the same cycle
   wire [15:0] set_mask   = (st == ST_STORE) ? (16'h0001 << ptr) : 16'h0000;
   wire [15:0] clr_mask   = wr_flag ? hwdata_i[15:0] : 16'h0000;
   wire [15:0] next_flags = (flags & ~clr_mask) | set_mask;

   // successive approximation keeps a bit when input is not below it
   wire [11:0] trial_bit = SAR_MSB >> bit_cnt;
   wire [11:0] sar_keep  = comparator_i ? sar : (sar & ~trial_bit);
   wire [11:0] next_sar  = sar_keep | (trial_bit >> 1);
   // Trial code comes straight from the register, so the core sees no glitches
   assign dac_code_o = sar;

   // Read data selection
   wire [31:0] stat_word = {31'h0, busy_o};
   wire [31:0] rd_mux =
      (addr_q == OFS_CTL_A) ? {16'h0, ctl_a} :
      (addr_q == OFS_CTL_B) ? {16'h0, ctl_b} :
      (addr_q == OFS_FLAG)  ? {16'h0, flags} :
      (addr_q == OFS_STAT)  ? stat_word :
      hit_entry             ? {24'h0, entry[widx]} :
      hit_result            ? {20'h0, mem_rdata} : 32'h0;

   // Reads take one wait state for the registered memory read
   assign hreadyout_o = ~rd_q;
   assign hresp_o     = 1'b0;

   assign core_power_on_o       = core_on;
   assign reference_power_on_o  = ctl_a[A_REF_ON];
   assign reference_level_sel_o = ctl_a[A_REF_LVL];
   // extended mode follows the trigger level
   assign sample_control_o = (st == ST_SAMPLE) & (pulse | trig);
   // busy from sampling start to result store
   assign busy_o      = ~(st == ST_IDLE);
   assign conv_tick_o = conv_tick;

   // one of twelve channels; codes above eleven connect nothing
   // unselected channels isolated with node grounded
   assign channel_connect_o = (connect && chan_out < 4'(N_CHAN))
                              ? (12'h001 << chan_out) : 12'h000;
   assign channel_ground_o  = ~channel_connect_o;

   // one divided tick times sampling and conversion
   sasc_clkdiv u_clkdiv (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .src_i     ({osc_clk_i, aux_clk_i, main_clk_i, sub_main_clk_i}),
      .sel_i     (ctl_b[B_CLK_SRC +: 2]),
      .div_i     (ctl_b[B_CLK_DIV +: 3]),
      .tick_o    (conv_tick)
   );

   sasc_mem #(.DEPTH(N_ENTRY), .WIDTH(12)) u_mem (
      .clk_sys_i (clk_sys_i),
      .we_i      (st == ST_STORE),
      .waddr_i   (ptr),
      .wdata_i   (sar),
      .re_i      (acc & ~hwrite_i),
      .raddr_i   (haddr_i[5:2]),
      .rdata_o   (mem_rdata)
   );

   // Sample and convert sequencing
   always_comb begin
      next_st = st;
      case (st)
         ST_IDLE:   if (can_start && trig_rise) next_st = ST_SAMPLE;
         // mode bit chooses pulse timer or trigger level
         ST_SAMPLE: if (pulse ? (conv_tick && samp_cnt == samp_last) : !trig) begin
            next_st = ST_SYNC;
         end
         // falling edge waits for a conversion tick
         ST_SYNC:   if (conv_tick) next_st = ST_CONV;
         ST_CONV:   if (conv_tick && bit_cnt == CONV_LAST) next_st = ST_STORE;
         ST_STORE:  next_st = ST_IDLE;
         default:   next_st = ST_IDLE;
      endcase
      if (abort) next_st = ST_IDLE;
   end

   // State and counters
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         st       <= ST_IDLE;
         trig_q   <= 1'b0;
         samp_cnt <= 6'h0;
         bit_cnt  <= 4'h0;
         sar      <= 12'h000;
      end else begin
         st     <= next_st;
         trig_q <= trig;
         if (st != ST_SAMPLE) samp_cnt <= 6'h0;
         else if (conv_tick) samp_cnt <= samp_cnt + 6'h1;
         if (st == ST_SYNC) begin
            bit_cnt <= 4'h0;
            sar     <= SAR_MSB;
         end else if (st == ST_CONV && conv_tick) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt < CONV_LAST) sar <= next_sar;
         end
      end
   end

   // entry pointer and sequence progress per mode
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ptr       <= 4'h0;
         in_seq    <= 1'b0;
         done_lock <= 1'b0;
      end else begin
         if (st == ST_IDLE && next_st == ST_SAMPLE && !in_seq) ptr <= start_addr;
         if (st == ST_STORE) begin
            in_seq <= seq_more;
            // Sequences roll over from entry 15 to entry 0
            if (seq_more) ptr <= ptr + 4'h1;
            // Once-only modes on a timer need arm toggled before the next run
            if (!mode[1] && !seq_more && trg_sel != TRG_SW) done_lock <= 1'b1;
         end
         if (abort) in_seq <= 1'b0;
         if (!arm) done_lock <= 1'b0;
      end
   end

   // open the old channel before closing the new one
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         chan_out <= 4'h0;
         connect  <= 1'b0;
      end else if (chan_out != cur_chan) begin
         chan_out <= cur_chan;
         connect  <= 1'b0;
      end else begin
         connect  <= sample_control_o;
      end
   end

   // Registers written by software
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ctl_a <= CTL_RST;
         ctl_b <= CTL_RST;
         flags <= CTL_RST;
         for (int i = 0; i < N_ENTRY; i++) entry[i] <= ENTRY_RST;
      end else begin
         ctl_a <= next_ctl_a;
         ctl_b <= next_ctl_b;
         flags <= next_flags;
         if (wr_entry) entry[widx] <= hwdata_i[7:0];
      end
   end

   // Bus data phase tracking
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         wr_q     <= 1'b0;
         rd_q     <= 1'b0;
         addr_q   <= 32'h0;
         hrdata_o <= 32'h0;
      end else begin
         wr_q <= acc & hwrite_i;
         rd_q <= acc & ~hwrite_i;
         if (acc) addr_q <= haddr_i;
         if (rd_q) hrdata_o <= rd_mux;
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   sequence s_conv_end;
      st == ST_CONV && conv_tick && bit_cnt == CONV_LAST && !abort;
   endsequence
   sequence s_stored;
      st == ST_STORE ##1 st == ST_IDLE;
   endsequence

   property p_conv_len;
      s_conv_end |=> s_stored;
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

   property p_conv_cnt;
      $rose(st == ST_CONV) |-> bit_cnt == 4'h0 && sar == SAR_MSB;
   endproperty
   a_conv_cnt: assert property (p_conv_cnt) else $error("conversion not from msb");

   property p_no_arm;
      (st == ST_IDLE && !arm && !in_seq) |=> st == ST_IDLE;
   endproperty
   a_no_arm: assert property (p_no_arm) else $error("start while not armed");

   property p_core_off;
      (st == ST_IDLE && !core_on) |=> st == ST_IDLE;
   endproperty
   a_core_off: assert property (p_core_off) else $error("start with core off");

   property p_lock;
      (wr_ctl_b && arm) |=> $stable(ctl_b);
   endproperty
   a_lock: assert property (p_lock) else $error("locked control changed");

   property p_flag;
      (st == ST_STORE) |=> flags[$past(ptr)];
   endproperty
   a_flag: assert property (p_flag) else $error("written flag not set");

   property p_bbm;
      $changed(chan_out) |-> channel_connect_o == 12'h000;
   endproperty
   a_bbm: assert property (p_bbm) else $error("make before break");

   property p_iso;
      !sample_control_o |=> channel_connect_o == 12'h000;
   endproperty
   a_iso: assert property (p_iso) else $error("channel left connected");

   property p_start;
      (st == ST_IDLE && can_start && trig_rise && arm) |=> busy_o && st == ST_SAMPLE;
   endproperty
   a_start: assert property (p_start) else $error("rising trigger ignored");

   property p_pulse;
      (st == ST_SAMPLE && pulse && conv_tick && samp_cnt == samp_last && !abort)
         |=> st == ST_SYNC && !sample_control_o;
   endproperty
   a_pulse: assert property (p_pulse) else $error("pulse sample length wrong");

   property p_ext;
      (st == ST_SAMPLE && !pulse) |-> sample_control_o == trig;
   endproperty
   a_ext: assert property (p_ext) else $error("extended sample not following trigger");

   property p_sync;
      (st == ST_SYNC && !conv_tick && !abort) |=> st == ST_SYNC;
   endproperty
   a_sync: assert property (p_sync) else $error("conversion started off tick");

endmodule : sasc_top

// *** core/sasc_pkg.sv ***
// Constants, register map and types for the converter sample control block
// Summary of operation
// - Input at or above upper limit gives all ones; at or below lower gives zero.
// - Result equals 4095 times input offset over reference span.
// - Converter core is powered only while core power bit is set.
// - Most control bits change only while the arm bit is clear.
// - No conversion starts while the arm bit is clear, except the remaining entries of a sequence already started.
// - One selected clock steps conversions and times pulse sampling.
// - Conversion clock comes from one of four selectable sources.
// - Selected conversion clock source is divided by one to eight.
// - Channel chosen from eight external and four internal inputs.
// - Channel switching opens the old channel before connecting the new.
// - Unselected channels are isolated and their middle node grounded.
// - Internal reference is powered only while reference power bit is set.
// - Reference level bit chooses the higher or lower reference level.
// - Sample and convert begins on a rising trigger edge.
// - Trigger comes from software bit or one of three timer outputs.
// - Trigger invert bit flips the selected trigger polarity.
// - Sampling stays active while the sample control signal is high.
// - Falling sample control starts a conversion of exactly thirteen clocks.
// - One sample mode bit chooses extended or pulse sample timing.
// - Sixteen control and result entries convert and store unattended.
// - Extended mode follows the trigger; falling edge syncs to conversion clock.
// - Pulse mode holds sampling for four times (programmed value plus one) clocks, two fields.
// - Two-bit field selects single, sequence, repeat single, repeat sequence.
// - Writing a result into an entry sets that entry's written flag.
package sasc_pkg;

   // Register byte offsets
   localparam logic [31:0] OFS_CTL_A  = 32'h0000_0000;
   localparam logic [31:0] OFS_CTL_B  = 32'h0000_0004;
   localparam logic [31:0] OFS_FLAG   = 32'h0000_0008;
   localparam logic [31:0] OFS_STAT   = 32'h0000_000C;
   localparam logic [31:0] OFS_ENTRY  = 32'h0000_0040;
   localparam logic [31:0] OFS_RESULT = 32'h0000_0080;

   // Control word a fields
   localparam int A_SW_START = 0;
   localparam int A_ARM      = 1;
   localparam int A_CORE_ON  = 4;
   localparam int A_REF_ON   = 5;
   localparam int A_REF_LVL  = 6;
   localparam int A_SHT_LO   = 8;
   localparam int A_SHT_HI   = 12;

   // Control word b fields
   localparam int B_SEQ_MODE = 0;
   localparam int B_CLK_SRC  = 3;
   localparam int B_CLK_DIV  = 5;
   localparam int B_TRG_INV  = 8;
   localparam int B_PULSE    = 9;
   localparam int B_TRG_SRC  = 10;
   localparam int B_START    = 12;

   // Control entry fields
   localparam int E_CHAN = 0;
   localparam int E_EOS  = 7;

   // Reset values
   localparam logic [15:0] CTL_RST   = 16'h0000;
   localparam logic [7:0]  ENTRY_RST = 8'h00;

   // Converter figures
   localparam int          N_ENTRY    = 16;
   localparam int          N_CHAN     = 12;
   localparam logic [3:0]  CONV_LAST  = 4'hC;
   localparam logic [11:0] SAR_MSB    = 12'h800;
   localparam logic [11:0] FULL_SCALE = 12'hFFF;

   // Conversion modes
   localparam logic [1:0] MODE_SINGLE = 2'h0;
   localparam logic [1:0] MODE_SEQ    = 2'h1;
   localparam logic [1:0] MODE_REP    = 2'h2;
   localparam logic [1:0] MODE_REPSEQ = 2'h3;

   // Trigger sources
   localparam logic [1:0] TRG_SW  = 2'h0;
   localparam logic [1:0] TRG_TA1 = 2'h1;
   localparam logic [1:0] TRG_TB0 = 2'h2;
   localparam logic [1:0] TRG_TB1 = 2'h3;

   typedef enum logic [4:0] {
      ST_IDLE   = 5'b00001,
      ST_SAMPLE = 5'b00010,
      ST_SYNC   = 5'b00100,
      ST_CONV   = 5'b01000,
      ST_STORE  = 5'b10000
   } sasc_state_t;

endpackage : sasc_pkg

// *** core/sasc_clkdiv.sv ***
// Conversion clock source select and integer divider, as a tick
`timescale 1ns/1ps
module sasc_clkdiv (
   input  wire logic       clk_sys_i,  // System clock
   input  wire logic       rst_i,      // Async reset
   input  wire logic [3:0] src_i,      // Source levels
   input  wire logic [1:0] sel_i,      // Source select
   input  wire logic [2:0] div_i,      // Ratio minus one
   output logic            tick_o      // Divided tick
);
   logic       src_q;
   logic [2:0] cnt;

   // Rising edge of the chosen source level
   wire src_now  = src_i[sel_i];
   wire src_rise = src_now & ~src_q;
   wire wrap     = (cnt >= div_i);

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         src_q  <= 1'b0;
         cnt    <= 3'h0;
         tick_o <= 1'b0;
      end else begin
         src_q  <= src_now;
         tick_o <= src_rise & wrap;
         if (src_rise) begin
            cnt <= wrap ? 3'h0 : cnt + 3'h1;
         end
      end
   end
endmodule : sasc_clkdiv

// *** core/sasc_mem.sv ***
// Result memory with registered read port
`timescale 1ns/1ps
module sasc_mem #(
   parameter int DEPTH = 16,
   parameter int WIDTH = 12
) (
   input  wire logic                     clk_sys_i, // System clock
   input  wire logic                     we_i,      // Write strobe
   input  wire logic [$clog2(DEPTH)-1:0] waddr_i,   // Write index
   input  wire logic [WIDTH-1:0]         wdata_i,   // Write data
   input  wire logic                     re_i,      // Read strobe
   input  wire logic [$clog2(DEPTH)-1:0] raddr_i,   // Read index
   output logic      [WIDTH-1:0]         rdata_o    // Registered read data
);
   logic [WIDTH-1:0] mem [DEPTH];

   // Contents are undefined until written; no reset on storage
   always_ff @(posedge clk_sys_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      if (re_i) begin
         rdata_o <= mem[raddr_i];
      end
   end
endmodule : sasc_mem

// *** tb/sasc_far_model.sv ***
// Far-side model: analog channels, clock sources and timer outputs
`timescale 1ns/1ps
module sasc_far_model (
   input  wire logic        clk_sys_i,      // System clock
   input  wire logic [11:0] dac_code_i,     // Trial code from the block
   input  wire logic [11:0] chan_connect_i, // One-hot channel switch
   output logic             comparator_o,   // Held level >= trial code
   output logic [3:0]       clk_src_o,      // Clock source levels
   output logic [2:0]       tmr_o           // Timer trigger outputs
);
   localparam int HALF [4] = '{40, 60, 100, 140};
   logic [11:0] vin [12]; // Input level per channel, as a code
   logic [11:0] held;     // Level kept on the sample capacitor
   initial begin
      held = 12'h000;
      tmr_o = 3'h0;
      clk_src_o = 4'h0;
      foreach (vin[i]) begin
         vin[i] = 12'h000;
      end
   end
   // sources run free
   // Offset of 5 ns keeps source edges away from system clock edges
   for (genvar g = 0; g < 4; g++) begin : g_src
      initial begin
         #5;
         forever #(HALF[g]) clk_src_o[g] = ~clk_src_o[g];
      end
   end
   always @(posedge clk_sys_i) begin
      foreach (vin[i]) begin
         if (chan_connect_i[i]) begin
            held <= vin[i];
         end
      end
   end
   // reference unused, so no settling wait applies
   assign comparator_o = (held >= dac_code_i);
   // Timer outputs change just after a clock edge
   task automatic set_tmr(input logic [2:0] v);
      @(posedge clk_sys_i);
      tmr_o <= v;
   endtask : set_tmr
endmodule : sasc_far_model

// *** tb/sasc_top_tb.sv ***
// Self-checking bench for the converter sample control block
`timescale 1ns/1ps
module sasc_top_tb;
   import sasc_pkg::*;
   // Control b value beside expected tick spacing in cycles
   localparam logic [31:0] ROWS [5] = '{32'h0000_0002, 32'h0029_0006,
      32'h1552_000F, 32'hFFFB_0038, 32'h20E0_0010};
   logic        clk_sys_i, rst_i, hsel_i, hwrite_i, hready, hresp, cmp;
   logic        core_on, ref_on, ref_lvl, samp, busy, tick;
   logic [1:0]  htrans_i;
   logic [2:0]  tmr;
   logic [3:0]  src;
   logic [11:0] dac, conn, gnd;
   logic [31:0] haddr_i, hwdata_i, hrdata, rdv;
   int          n_fail = 0, checked = 0, n;
   sasc_top DUT (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .sub_main_clk_i(src[0]), .main_clk_i(src[1]), .aux_clk_i(src[2]),
      .osc_clk_i(src[3]), .tmr_a1_i(tmr[0]), .tmr_b0_i(tmr[1]), .tmr_b1_i(tmr[2]),
      .comparator_i(cmp), .core_power_on_o(core_on), .reference_power_on_o(ref_on),
      .reference_level_sel_o(ref_lvl), .sample_control_o(samp), .dac_code_o(dac),
      .channel_connect_o(conn), .channel_ground_o(gnd), .busy_o(busy),
      .conv_tick_o(tick));
   sasc_far_model far (
      .clk_sys_i(clk_sys_i), .dac_code_i(dac), .chan_connect_i(conn),
      .comparator_o(cmp), .clk_src_o(src), .tmr_o(tmr));
   // 25 MHz system clock
   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // One bus transfer; read data taken at the closing edge of its data phase
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
      hsel_i   <= 1'b1;
      htrans_i <= 2'h2;
      haddr_i  <= a;
      hwrite_i <= wr;
      do @(posedge clk_sys_i); while (hready !== 1'b1);
      hsel_i   <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(posedge clk_sys_i); while (hready !== 1'b1);
      rdv = hrdata;
      // A write lands at this edge; let it settle before callers look at outputs
      if (wr) @(posedge clk_sys_i);
   endtask : xfer
   task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(nm, e, rdv);
   endtask : rdchk
   // Bounded wait, so a stuck flag fails instead of hanging
   task automatic wait_busy(input logic v, input int lim);
      for (int k = 0; k < lim && busy !== v; k++) @(posedge clk_sys_i);
      chk("busy", {31'h0, v}, {31'h0, busy});
   endtask : wait_busy
   // Spacing of the third tick after a divider change
   task automatic gap_of(output int g);
      for (int j = 0; j < 3; j++) begin
         g = 0;
         do begin
            @(posedge clk_sys_i);
            g++;
         end while (tick !== 1'b1 && g < 500);
      end
   endtask : gap_of
   // Pulse-mode software conversion into entry ch, sampling channel ch
   task automatic conv(input logic [11:0] code, input logic [3:0] ch);
      far.vin[ch] = code;
      xfer(1'b1, OFS_ENTRY + {26'h0, ch, 2'h0}, {28'h0, ch});
      xfer(1'b1, OFS_CTL_A, 32'h10);
      xfer(1'b1, OFS_CTL_B, {16'h0, ch, 12'h218});
      xfer(1'b1, OFS_CTL_A, 32'h12);
      xfer(1'b1, OFS_CTL_A, 32'h13);
      wait_busy(1'b1, 20);
      repeat (3) @(posedge clk_sys_i);
      chk("connect", {20'h0, 12'h1 << ch}, {20'h0, conn});
      chk("ground", {20'h0, ~(12'h1 << ch)}, {20'h0, gnd});
      rdchk("status", OFS_STAT, 32'h1);
      n = 0;
      for (int k = 0; k < 500 && busy !== 1'b0; k++) begin
         @(posedge clk_sys_i);
         if (busy === 1'b1 && samp === 1'b0 && tick === 1'b1) n++;
      end
      chk("conv ticks", 32'd14, n);
      chk("dac", {20'h0, code}, {20'h0, dac});
      rdchk("result", OFS_RESULT + {26'h0, ch, 2'h0}, {20'h0, code});
      rdchk("flag", OFS_FLAG, {16'h0, 16'h1 << ch});
      xfer(1'b1, OFS_FLAG, 32'hFFFF);
   endtask : conv
   task automatic final_report;
      if (n_fail == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : final_report
   initial begin
      #(40 * 30000);
      n_fail++;
      final_report;
   end
   initial begin
      rst_i = 1'b1;
      hsel_i = 1'b0;
      htrans_i = 2'h0;
      hwrite_i = 1'b0;
      haddr_i = 32'h0;
      hwdata_i = 32'h0;
      repeat (2) @(posedge clk_sys_i);
      chk("reset pins", 32'h20, {25'h0, hresp, hready, busy, samp, core_on, ref_on, ref_lvl});
      chk("reset switch", 32'hFFF, {8'h0, conn, gnd});
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      rdchk("ctl a", OFS_CTL_A, 32'h0);
      xfer(1'b1, 32'h20, 32'hFFFF);
      rdchk("unmapped", 32'h20, 32'h0);
      // Table of divider and field settings
      foreach (ROWS[i]) begin
         xfer(1'b1, OFS_CTL_B, {16'h0, ROWS[i][31:16]});
         rdchk("ctl b", OFS_CTL_B, {16'h0, ROWS[i][31:16]});
         gap_of(n);
         chk("tick gap", ROWS[i][15:0], n);
      end
      xfer(1'b1, OFS_CTL_A, 32'h60);
      chk("ref", 32'h3, {30'h0, ref_on, ref_lvl});
      xfer(1'b1, OFS_CTL_A, 32'h20);
      chk("ref", 32'h2, {30'h0, ref_on, ref_lvl});
      xfer(1'b1, OFS_CTL_B, 32'h218);
      xfer(1'b1, OFS_CTL_A, 32'h11);
      repeat (60) @(posedge clk_sys_i);
      chk("unarmed busy", 32'h0, {31'h0, busy});
      xfer(1'b1, OFS_CTL_A, 32'h12);
      xfer(1'b1, OFS_CTL_B, 32'h1);
      rdchk("locked b", OFS_CTL_B, 32'h218);
      xfer(1'b1, OFS_CTL_A, 32'h0);
      rdchk("locked a", OFS_CTL_A, 32'h10);
      chk("core on", 32'h1, {31'h0, core_on});
      xfer(1'b1, OFS_CTL_A, 32'h0);
      chk("core off", 32'h0, {31'h0, core_on});
      conv(12'h000, 4'h0);
      conv(12'hFFF, 4'hB);
      conv(12'hA5C, 4'h5);
      conv(12'h001, 4'h3);
      xfer(1'b1, OFS_CTL_A, 32'h10);
      xfer(1'b1, OFS_CTL_B, 32'h018);
      xfer(1'b1, OFS_CTL_A, 32'h12);
      xfer(1'b1, OFS_CTL_A, 32'h13);
      repeat (60) @(posedge clk_sys_i);
      chk("extended", 32'h1, {31'h0, samp});
      xfer(1'b1, OFS_CTL_A, 32'h12);
      chk("extended", 32'h0, {31'h0, samp});
      wait_busy(1'b0, 400);
      // Each timer source, plain and inverted
      for (int k = 1; k < 4; k++) begin
         for (int v = 0; v < 2; v++) begin
            xfer(1'b1, OFS_CTL_A, 32'h10);
            xfer(1'b1, OFS_CTL_B, 32'h218 | (k << 10) | (v << 8));
            xfer(1'b1, OFS_CTL_A, 32'h12);
            far.set_tmr(3'h1 << (k - 1));
            repeat (4) @(posedge clk_sys_i);
            chk("trigger", 32'(1 - v), {31'h0, busy});
            far.set_tmr(3'h0);
            wait_busy(1'b1, 20);
            wait_busy(1'b0, 400);
         end
      end
      // Sequence once: one software edge per entry, pointer stops at the end mark
      xfer(1'b1, OFS_FLAG, 32'hFFFF);
      far.vin[2] = 12'h123;
      far.vin[3] = 12'h456;
      xfer(1'b1, OFS_ENTRY + 32'h8, 32'h2);
      xfer(1'b1, OFS_ENTRY + 32'hC, 32'h83);
      xfer(1'b1, OFS_CTL_A, 32'h10);
      xfer(1'b1, OFS_CTL_B, 32'h2219);
      xfer(1'b1, OFS_CTL_A, 32'h12);
      for (int k = 0; k < 2; k++) begin
         xfer(1'b1, OFS_CTL_A, 32'h13);
         wait_busy(1'b1, 20);
         wait_busy(1'b0, 400);
      end
      rdchk("seq first", OFS_RESULT + 32'h8, 32'h123);
      rdchk("seq last", OFS_RESULT + 32'hC, 32'h456);
      rdchk("seq flags", OFS_FLAG, 32'hC);
      final_report;
   end
endmodule : sasc_top_tb
